// ---- sap_regs.svh ----
// Purpose: register map, field positions and reset values of the partition block
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes: functional notes below
// Functional notes
// - every transaction carries security on prot bit one, low secure, high non-secure
// - firewall before each slave allows or rejects by transaction security
// - each slave is secure-only until software programs it otherwise
// - violation answer is selectable: bus error or bus failure
// - cache lookup key is the 32-bit address plus a security top bit
// - caches hold secure and non-secure lines at the same time
// - each core has secure and non-secure virtual processors, each own resources
// - secure entry on monitor call, or configured irq, fast irq, aborts
// - on switch the world is saved and restored at next switch or return
// - non-secure, secure and monitor vector bases, each relocatable at runtime
// - non-secure accesses cannot read or change secure interrupt configuration
// - pending secure interrupts always win over non-secure ones
// - two inputs per core gate secure privileged and secure user debug
// - global visibility input low removes all debug visibility of the core
// - each core has its own independent set of debug inputs
`ifndef SAP_REGS_SVH
`define SAP_REGS_SVH
`define SAP_OFS_CTRL     6'h00
`define SAP_OFS_SLVSEC   6'h04
`define SAP_OFS_IRQSEC   6'h08
`define SAP_OFS_STATUS   6'h0c
`define SAP_OFS_MASK     6'h10
`define SAP_OFS_WORLD    6'h14
`define SAP_OFS_VEC_NS   6'h18
`define SAP_OFS_VEC_S    6'h1c
`define SAP_OFS_VEC_MON  6'h20
`define SAP_OFS_TRAPCFG  6'h24
`define SAP_CTRL_FAIL    0
`define SAP_ST_VIOL      0
`define SAP_ST_ENTRY     1
`define SAP_ST_BLOCK     2
`define SAP_TRAP_IRQ     0
`define SAP_TRAP_FIQ     1
`define SAP_TRAP_DABT    2
`define SAP_TRAP_PABT    3
`define SAP_PROT_NS      1
`define SAP_RST_SLVSEC   8'hff
`define SAP_RST_VEC      32'h0000_0000
`endif

// ---- sap_pkg.sv ----
// Purpose: shared types of the partition block
// Assumes: nothing beyond the register header
// Notes: world codes are one-hot
package sap_pkg;
  typedef enum logic [2:0] {
    SAP_W_NS  = 3'b001,
    SAP_W_MON = 3'b010,
    SAP_W_SEC = 3'b100
  } sap_world_t;
endpackage : sap_pkg

// ---- sap_fw.sv ----
// Purpose: slave firewall, one registered decision per transaction
// Assumes: slave selected by address bits 31:29, eight slaves
// Notes: a rejected access produces no forward strobe at all
`timescale 1ns/1ps
`default_nettype none
`include "sap_regs.svh"
module sap_fw (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_valid,
  input  wire logic [31:0] i_addr,
  input  wire logic [2:0]  i_prot,
  input  wire logic [7:0]  i_slv_sec,
  input  wire logic        i_fail_mode,
  output logic             o_fwd_valid,
  output logic [31:0]      o_fwd_addr,
  output logic [2:0]       o_fwd_prot,
  output logic             o_err,
  output logic             o_fail,
  output logic             o_viol
);
  logic deny;
  // non-secure request to a slave still marked secure is refused
  assign deny = i_prot[`SAP_PROT_NS] & i_slv_sec[i_addr[31:29]];

  // decision registered so the slave side sees clean one-cycle strobes
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_fwd_valid <= 1'b0;
      o_fwd_addr  <= 32'h0000_0000;
      o_fwd_prot  <= 3'h0;
      o_err       <= 1'b0;
      o_fail      <= 1'b0;
      o_viol      <= 1'b0;
    end else begin
      o_fwd_valid <= i_valid & ~deny;
      o_err       <= i_valid & deny & ~i_fail_mode;
      o_fail      <= i_valid & deny & i_fail_mode;
      o_viol      <= i_valid & deny;
      if (i_valid & ~deny) begin
        o_fwd_addr <= i_addr;
        o_fwd_prot <= i_prot;
      end
    end
  end

  AST_FW_NO_LEAK: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_valid && deny) |=> (!o_fwd_valid && (o_err || o_fail)))
    else $error("refused access was forwarded");
  AST_FW_MODE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_valid && deny && i_fail_mode) |=> (o_fail && !o_err))
    else $error("failure mode not honoured");
endmodule : sap_fw
`default_nettype wire

// ---- sap_top.sv ----
// Purpose: security partition: firewall, world control, tags, irq rank, debug gate
// Assumes: two cores, eight slaves, eight interrupt lines, 16-line tag store
// Notes: register writes to security settings need a secure bus access
`timescale 1ns/1ps
`default_nettype none
`include "sap_regs.svh"
module sap_top (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // avalon-mm slave, i_avs_prot_ns tags the access security
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic        i_avs_prot_ns,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic             o_irq,
  // master transaction toward the slaves
  input  wire logic        i_mst_valid,
  input  wire logic [31:0] i_mst_addr,
  input  wire logic [2:0]  i_mst_prot,
  output logic             o_slv_valid,
  output logic [31:0]      o_slv_addr,
  output logic [2:0]       o_slv_prot,
  output logic             o_slv_err,
  output logic             o_slv_fail,
  // per-core world events
  input  wire logic [1:0]  i_secure_monitor_call,
  input  wire logic [1:0]  i_irq_exc,
  input  wire logic [1:0]  i_fast_interrupt_request,
  input  wire logic [1:0]  i_dabt_exc,
  input  wire logic [1:0]  i_pabt_exc,
  input  wire logic [1:0]  i_world_switch,
  input  wire logic [1:0]  i_exc_return,
  input  wire logic [1:0]  i_core_priv,
  output logic [1:0]       o_core_prot_ns,
  output logic [1:0][31:0] o_vec_base,
  // cache tag lookup
  input  wire logic        i_lk_valid,
  input  wire logic [31:0] i_lk_addr,
  input  wire logic        i_lk_ns,
  output logic             o_lk_hit,
  output logic             o_lk_done,
  // interrupt distributor ranking
  input  wire logic [7:0]  i_int_pend,
  output logic             o_int_valid,
  output logic [2:0]       o_int_id,
  output logic             o_int_secure,
  // debug pins, asynchronous
  input  wire logic [1:0]  i_sec_priv_dbg_en,
  input  wire logic [1:0]  i_sec_user_dbg_en,
  input  wire logic [1:0]  i_global_debug_visibility_enable,
  output logic [1:0]       o_dbg_allow
);
  import sap_pkg::*;

  logic             fail_mode;
  logic [7:0]       slv_sec;
  logic [7:0]       int_sec;
  logic [2:0]       status;
  logic [2:0]       mask;
  logic [3:0]       trap_cfg;
  logic [31:0]      vec_ns;
  logic [31:0]      vec_s;
  logic [31:0]      vec_mon;
  sap_world_t       world [2];
  sap_world_t       saved [2];
  logic [1:0]       entry;
  logic             viol;
  logic             wr_go;
  logic             rd_go;
  logic             sec_acc;
  logic             blocked;
  logic [5:0]       dbg_s1;
  logic [5:0]       dbg_s2;
  logic [26:0]      tag_mem [16];
  logic [15:0]      tag_vld;
  logic [3:0]       lk_idx;
  logic [26:0]      lk_tag;
  logic [3:0]       pick_sec;
  logic [3:0]       pick_ns;

  // lowest index pending line wins within one security group
  function automatic logic [3:0] sap_pick(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int k = 7; k >= 0; k--) begin
      if (v[k]) r = {1'b1, 3'(k)};
    end
    return r;
  endfunction : sap_pick

  // request accepted on the edge where waitrequest is already low
  assign wr_go   = i_avs_write & ~o_avs_waitrequest;
  assign rd_go   = i_avs_read & ~o_avs_waitrequest;
  assign sec_acc = ~i_avs_prot_ns;
  // non-secure write aimed at security settings is dropped
  assign blocked = wr_go & i_avs_prot_ns &
                   (i_avs_address == `SAP_OFS_IRQSEC || i_avs_address == `SAP_OFS_SLVSEC ||
                    i_avs_address == `SAP_OFS_CTRL || i_avs_address == `SAP_OFS_VEC_S ||
                    i_avs_address == `SAP_OFS_VEC_MON || i_avs_address == `SAP_OFS_TRAPCFG);

  // one wait cycle per access, then a single ready cycle
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_avs_waitrequest <= 1'b1;
    end else if (!o_avs_waitrequest) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= ~(i_avs_read | i_avs_write);
    end
  end

  // configuration registers, secure bus masters only apart from mask and vec_ns
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fail_mode <= 1'b0;
      slv_sec   <= `SAP_RST_SLVSEC;
      int_sec   <= 8'h00;
      mask      <= 3'h0;
      trap_cfg  <= 4'h0;
      vec_ns    <= `SAP_RST_VEC;
      vec_s     <= `SAP_RST_VEC;
      vec_mon   <= `SAP_RST_VEC;
    end else if (wr_go) begin
      unique case (i_avs_address)
        `SAP_OFS_CTRL:    if (sec_acc) fail_mode <= i_avs_writedata[`SAP_CTRL_FAIL];
        `SAP_OFS_SLVSEC:  if (sec_acc) slv_sec <= i_avs_writedata[7:0];
        `SAP_OFS_IRQSEC:  if (sec_acc) int_sec <= i_avs_writedata[7:0];
        `SAP_OFS_MASK:    mask <= i_avs_writedata[2:0];
        `SAP_OFS_TRAPCFG: if (sec_acc) trap_cfg <= i_avs_writedata[3:0];
        `SAP_OFS_VEC_NS:  vec_ns <= i_avs_writedata;
        `SAP_OFS_VEC_S:   if (sec_acc) vec_s <= i_avs_writedata;
        `SAP_OFS_VEC_MON: if (sec_acc) vec_mon <= i_avs_writedata;
        default: ;
      endcase
    end
  end

  // sticky events; a status read clears only the bits it reported, so an event
  // landing between the data capture and the clear is not lost; set wins
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      status <= 3'h0;
    end else begin
      status <= ((rd_go && i_avs_address == `SAP_OFS_STATUS) ?
                 (status & ~o_avs_readdata[2:0]) : status) |
                {blocked, |entry, viol};
    end
  end

  // level interrupt, registered so it comes straight from a flop
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(status & mask);
    end
  end

  // read data loaded in the wait cycle, stands through the ready cycle
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (o_avs_waitrequest && i_avs_read) begin
      unique case (i_avs_address)
        `SAP_OFS_CTRL:    o_avs_readdata <= {31'h0, fail_mode};
        `SAP_OFS_SLVSEC:  o_avs_readdata <= {24'h0, slv_sec};
        // non-secure readers see no interrupt security setting
        `SAP_OFS_IRQSEC:  o_avs_readdata <= sec_acc ? {24'h0, int_sec} : 32'h0;
        `SAP_OFS_STATUS:  o_avs_readdata <= {29'h0, status};
        `SAP_OFS_MASK:    o_avs_readdata <= {29'h0, mask};
        `SAP_OFS_WORLD:   o_avs_readdata <= {26'h0, world[1], world[0]};
        `SAP_OFS_VEC_NS:  o_avs_readdata <= vec_ns;
        `SAP_OFS_VEC_S:   o_avs_readdata <= sec_acc ? vec_s : 32'h0;
        `SAP_OFS_VEC_MON: o_avs_readdata <= sec_acc ? vec_mon : 32'h0;
        `SAP_OFS_TRAPCFG: o_avs_readdata <= {28'h0, trap_cfg};
        default:          o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // firewall in front of the slaves
  sap_fw u_fw (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_valid     (i_mst_valid),
    .i_addr      (i_mst_addr),
    .i_prot      (i_mst_prot),
    .i_slv_sec   (slv_sec),
    .i_fail_mode (fail_mode),
    .o_fwd_valid (o_slv_valid),
    .o_fwd_addr  (o_slv_addr),
    .o_fwd_prot  (o_slv_prot),
    .o_err       (o_slv_err),
    .o_fail      (o_slv_fail),
    .o_viol      (viol)
  );

  // monitor entry: call always, hardware exceptions only when enabled
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      entry[c] = (world[c] == SAP_W_NS) &&
                 (i_secure_monitor_call[c] ||
                  (i_irq_exc[c] && trap_cfg[`SAP_TRAP_IRQ]) ||
                  (i_fast_interrupt_request[c] && trap_cfg[`SAP_TRAP_FIQ]) ||
                  (i_dabt_exc[c] && trap_cfg[`SAP_TRAP_DABT]) ||
                  (i_pabt_exc[c] && trap_cfg[`SAP_TRAP_PABT]));
    end
  end

  // per-core world machine; the monitor remembers the world it came from
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      world[0] <= SAP_W_SEC;
      world[1] <= SAP_W_SEC;
      saved[0] <= SAP_W_SEC;
      saved[1] <= SAP_W_SEC;
    end else begin
      for (int c = 0; c < 2; c++) begin
        unique case (world[c])
          SAP_W_NS: begin
            if (entry[c]) begin
              saved[c] <= SAP_W_NS;
              world[c] <= SAP_W_MON;
            end
          end
          SAP_W_SEC: begin
            if (i_secure_monitor_call[c]) begin
              saved[c] <= SAP_W_SEC;
              world[c] <= SAP_W_MON;
            end
          end
          SAP_W_MON: begin
            if (i_exc_return[c]) begin
              world[c] <= saved[c];
            end else if (i_world_switch[c]) begin
              world[c] <= (saved[c] == SAP_W_NS) ? SAP_W_SEC : SAP_W_NS;
            end
          end
          default: world[c] <= SAP_W_SEC;
        endcase
      end
    end
  end

  // core bus security and active vector base follow the world
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_core_prot_ns <= 2'b00;
      o_vec_base     <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        o_core_prot_ns[c] <= (world[c] == SAP_W_NS);
        o_vec_base[c] <= (world[c] == SAP_W_NS)  ? vec_ns :
                         (world[c] == SAP_W_MON) ? vec_mon : vec_s;
      end
    end
  end

  // security bit picks the half of the store and sits in the tag
  assign lk_idx = {i_lk_ns, i_lk_addr[7:5]};
  assign lk_tag = {i_lk_ns, i_lk_addr[31:6]};

  // tag store: hit compares the 27 stored tag bits, a miss allocates
  always_ff @(posedge i_clk) begin
    if (i_lk_valid) begin
      tag_mem[lk_idx] <= lk_tag;
    end
  end

  // valid bits and lookup answer, one cycle after the request
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tag_vld   <= 16'h0000;
      o_lk_hit  <= 1'b0;
      o_lk_done <= 1'b0;
    end else begin
      o_lk_done <= i_lk_valid;
      o_lk_hit  <= i_lk_valid && tag_vld[lk_idx] && (tag_mem[lk_idx] == lk_tag);
      if (i_lk_valid) begin
        tag_vld[lk_idx] <= 1'b1;
      end
    end
  end

  // winner of each security group, bit 3 flags that the group has one
  assign pick_sec = sap_pick(i_int_pend & int_sec);
  assign pick_ns  = sap_pick(i_int_pend & ~int_sec);

  // ranking: any pending secure line beats every non-secure line
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_int_valid  <= 1'b0;
      o_int_id     <= 3'h0;
      o_int_secure <= 1'b0;
    end else begin
      o_int_valid  <= |i_int_pend;
      o_int_secure <= |(i_int_pend & int_sec);
      if (pick_sec[3]) begin
        o_int_id <= pick_sec[2:0];
      end else begin
        o_int_id <= pick_ns[2:0];
      end
    end
  end

  // debug pins cross in through two flops each
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dbg_s1 <= 6'h00;
      dbg_s2 <= 6'h00;
    end else begin
      dbg_s1 <= {i_global_debug_visibility_enable, i_sec_user_dbg_en, i_sec_priv_dbg_en};
      dbg_s2 <= dbg_s1;
    end
  end

  // each core uses only its own pins; non-secure debug needs only the global pin
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_dbg_allow <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        o_dbg_allow[c] <= dbg_s2[4+c] &&
                          ((world[c] == SAP_W_NS) ||
                           (i_core_priv[c] ? dbg_s2[c] : dbg_s2[2+c]));
      end
    end
  end

  sequence s_ns_entry(c);
    world[c] == SAP_W_NS && entry[c];
  endsequence
  sequence s_in_mon(c);
    world[c] == SAP_W_MON && saved[c] == SAP_W_NS;
  endsequence

  AST_ENTRY_MON: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s_ns_entry(0) |=> s_in_mon(0))
    else $error("core 0 did not enter monitor");
  AST_RETURN_NS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_in_mon(1) ##0 i_exc_return[1]) |=> world[1] == SAP_W_NS)
    else $error("core 1 return did not restore world");
  AST_PROT_WORLD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (world[0] == SAP_W_NS) |=> o_core_prot_ns[0])
    else $error("non-secure world drove secure prot");
  AST_VEC_MON: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (world[1] == SAP_W_MON) |=> o_vec_base[1] == $past(vec_mon))
    else $error("monitor vector base not selected");
  AST_IRQSEC_LOCK: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (wr_go && i_avs_prot_ns && i_avs_address == `SAP_OFS_IRQSEC) |=> $stable(int_sec))
    else $error("non-secure write changed interrupt security");
  AST_SEC_FIRST: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (|(i_int_pend & int_sec) && !wr_go) |=> (o_int_secure && int_sec[o_int_id]))
    else $error("non-secure interrupt ranked over secure");
  AST_DBG_GLOBAL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !dbg_s2[4] |=> !o_dbg_allow[0])
    else $error("debug visible with global enable low");
  AST_XWORLD_MISS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_lk_valid && tag_vld[lk_idx] && tag_mem[lk_idx] != lk_tag) |=> !o_lk_hit)
    else $error("lookup hit a line of another key or world");
  AST_DBG_SEC: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (world[1] == SAP_W_SEC && !dbg_s2[1] && !dbg_s2[3]) |=> !o_dbg_allow[1])
    else $error("secure debug allowed with both gates low");
endmodule : sap_top
`default_nettype wire

// ---- sap_mst_model.sv ----
// Purpose: far-side bus master model that feeds the partition firewall
// Assumes: one request for each go pulse, core0 shares the coherency port
// Notes: idle lines toggle, so a stale address never looks like a request
`timescale 1ns/1ps
`default_nettype none
module sap_mst_model (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_go,
  input  wire logic [31:0] i_addr,
  input  wire logic        i_ns,
  input  wire logic        i_coh,
  input  wire logic        i_core_ns,
  output logic             o_valid,
  output logic [31:0]      o_addr,
  output logic [2:0]       o_prot
);
  // one request cycle for each go; a coherent request follows its core
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_valid <= 1'b0;
      o_addr  <= 32'h0;
      o_prot  <= 3'h0;
    end else if (i_go) begin
      o_valid <= 1'b1;
      o_addr  <= i_addr;
      o_prot  <= {1'b0, (i_coh ? i_core_ns : i_ns), 1'b0};
    end else begin
      o_valid <= 1'b0;
      o_addr  <= ~o_addr;
      o_prot  <= ~o_prot;
    end
  end
endmodule : sap_mst_model
`default_nettype wire

// ---- sap_top_tb_top.sv ----
// Purpose: self-checking bench of the partition block
// Assumes: one 10 MHz clock, register bus answers through waitrequest
// Notes: expectations follow the register map; no random stimulus
`timescale 1ns/1ps
`default_nettype none
`include "sap_regs.svh"
module sap_top_tb_top;
  localparam logic [31:0] VB_NS = 32'h1000_0000;
  localparam logic [31:0] VB_S  = 32'h2000_0000;
  localparam logic [31:0] VB_M  = 32'h3000_0000;
  logic        clk, rst = 1'b1, rd = 1'b0, wr = 1'b0, pns = 1'b0, go = 1'b0;
  logic        gns = 1'b0, coh = 1'b0, lkv = 1'b0, lkns = 1'b0;
  logic        wreq, irq, sv, se, sf, lhit, ldone, iv, isec, mv;
  logic [5:0]  adr = 6'h0;
  logic [31:0] wdat = 32'h0, gadr = 32'h0, lka = 32'h0, rdat, sadr, ma;
  logic [1:0]  ev [7] = '{default: 2'b00};
  logic [1:0]  cpriv = 2'b01, dpriv = 2'b00, duser = 2'b00, dglob = 2'b00;
  logic [1:0]  cns, dallow;
  logic [1:0][31:0] vb;
  logic [2:0]  sprot, iid, mp;
  logic [7:0]  pend = 8'h0;
  int          num_errors = 0, compares = 0;

  // free-running clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  sap_mst_model MST (.i_clk(clk), .i_sys_rst(rst), .i_go(go), .i_addr(gadr), .i_ns(gns),
    .i_coh(coh), .i_core_ns(cns[0]), .o_valid(mv), .o_addr(ma), .o_prot(mp));

  sap_top DUT (.i_clk(clk), .i_sys_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_prot_ns(pns), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .o_irq(irq), .i_mst_valid(mv), .i_mst_addr(ma),
    .i_mst_prot(mp), .o_slv_valid(sv), .o_slv_addr(sadr), .o_slv_prot(sprot),
    .o_slv_err(se), .o_slv_fail(sf), .i_secure_monitor_call(ev[0]), .i_irq_exc(ev[1]),
    .i_fast_interrupt_request(ev[2]), .i_dabt_exc(ev[3]), .i_pabt_exc(ev[4]),
    .i_world_switch(ev[5]), .i_exc_return(ev[6]), .i_core_priv(cpriv),
    .o_core_prot_ns(cns), .o_vec_base(vb), .i_lk_valid(lkv), .i_lk_addr(lka),
    .i_lk_ns(lkns), .o_lk_hit(lhit), .o_lk_done(ldone), .i_int_pend(pend),
    .o_int_valid(iv), .o_int_id(iid), .o_int_secure(isec), .i_sec_priv_dbg_en(dpriv),
    .i_sec_user_dbg_en(duser), .i_global_debug_visibility_enable(dglob),
    .o_dbg_allow(dallow));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // request held until waitrequest is sampled low; a hang ends after 50 edges
  task automatic avs(input logic w, input logic [5:0] a, input logic [31:0] d,
                     input logic ns, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    pns <= ns;
    @(posedge clk);
    while (wreq !== 1'b0 && n < 50) begin
      n++;
      @(posedge clk);
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
  endtask : avs

  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d, input logic ns);
    logic [31:0] q;
    avs(1'b1, a, d, ns, q);
  endtask : wr_reg

  task automatic rd_chk(input logic [5:0] a, input logic ns, input logic [31:0] e,
                        input string nm);
    logic [31:0] q;
    avs(1'b0, a, 32'h0, ns, q);
    chk(nm, e, q);
  endtask : rd_chk

  // exp one-hot: 001 forwarded, 010 bus error, 100 bus failure
  task automatic fw(input logic [31:0] a, input logic ns, input logic [2:0] exp);
    @(posedge clk);
    go <= 1'b1;
    gadr <= a;
    gns <= ns;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    chk("firewall answer", 32'(exp), 32'({sf, se, sv}));
    if (exp == 3'b001) begin
      chk("forward addr", a, sadr);
      chk("forward prot ns", 32'(ns), 32'(sprot[1]));
    end
  endtask : fw

  task automatic pulse(input int k, input logic [1:0] m);
    @(posedge clk);
    ev[k] <= m;
    @(posedge clk);
    ev[k] <= 2'b00;
    @(posedge clk);
    #1;
  endtask : pulse

  task automatic wchk(input logic ns0, input logic [31:0] v0);
    chk("core0 ns", 32'(ns0), 32'(cns[0]));
    chk("core0 vector", v0, vb[0]);
  endtask : wchk

  task automatic lk(input logic [31:0] a, input logic ns, input logic hit);
    @(posedge clk);
    lkv <= 1'b1;
    lka <= a;
    lkns <= ns;
    @(posedge clk);
    lkv <= 1'b0;
    #1;
    chk("lookup done", 32'h1, 32'(ldone));
    chk("lookup hit", 32'(hit), 32'(lhit));
  endtask : lk

  task automatic rk(input logic [7:0] p, input logic [2:0] id, input logic sec);
    @(posedge clk);
    pend <= p;
    repeat (2) @(posedge clk);
    #1;
    chk("int winner", {27'h0, 1'b1, id, sec}, {27'h0, iv, iid, isec});
  endtask : rk

  // debug pins are synchronised, so give them four edges to land
  task automatic dbg(input logic [1:0] sp, input logic [1:0] su, input logic [1:0] gl,
                     input logic [1:0] exp);
    @(posedge clk);
    dpriv <= sp;
    duser <= su;
    dglob <= gl;
    repeat (4) @(posedge clk);
    #1;
    chk("debug allow", 32'(exp), 32'(dallow));
  endtask : dbg

  task automatic report_and_stop;
    if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end

  // main sequence: reset, firewall, interrupts, worlds, tags
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`SAP_OFS_SLVSEC, 1'b0, 32'hff, "slave security");
    rd_chk(`SAP_OFS_WORLD, 1'b0, 32'h24, "world");
    rd_chk(6'h3c, 1'b0, 32'h0, "unmapped");
    dbg(2'b01, 2'b00, 2'b11, 2'b01);
    dbg(2'b00, 2'b10, 2'b11, 2'b10);
    dbg(2'b11, 2'b11, 2'b10, 2'b10);
    fw(32'h0000_0100, 1'b0, 3'b001);
    fw(32'h0000_0100, 1'b1, 3'b010);
    wr_reg(`SAP_OFS_CTRL, 32'h1, 1'b0);
    fw(32'h2000_0000, 1'b1, 3'b100);
    wr_reg(`SAP_OFS_CTRL, 32'h0, 1'b0);
    wr_reg(`SAP_OFS_SLVSEC, 32'hfe, 1'b0);
    fw(32'h0000_0040, 1'b1, 3'b001);
    fw(32'he000_0000, 1'b1, 3'b010);
    wr_reg(`SAP_OFS_SLVSEC, 32'h0, 1'b1);
    rd_chk(`SAP_OFS_SLVSEC, 1'b0, 32'hfe, "slave security");
    rd_chk(`SAP_OFS_STATUS, 1'b0, 32'h5, "status");
    rd_chk(`SAP_OFS_STATUS, 1'b0, 32'h0, "status cleared");
    wr_reg(`SAP_OFS_MASK, 32'h1, 1'b1);
    fw(32'he000_0000, 1'b1, 3'b010);
    repeat (3) @(posedge clk);
    chk("irq raised", 32'h1, 32'(irq));
    rd_chk(`SAP_OFS_STATUS, 1'b0, 32'h1, "status");
    repeat (3) @(posedge clk);
    chk("irq cleared", 32'h0, 32'(irq));
    wr_reg(`SAP_OFS_MASK, 32'h0, 1'b1);
    fw(32'he000_0000, 1'b1, 3'b010);
    repeat (3) @(posedge clk);
    chk("irq masked", 32'h0, 32'(irq));
    rd_chk(`SAP_OFS_STATUS, 1'b0, 32'h1, "status");
    wr_reg(`SAP_OFS_IRQSEC, 32'h80, 1'b0);
    wr_reg(`SAP_OFS_IRQSEC, 32'h0, 1'b1);
    rd_chk(`SAP_OFS_IRQSEC, 1'b1, 32'h0, "irq security ns");
    rd_chk(`SAP_OFS_IRQSEC, 1'b0, 32'h80, "irq security");
    rk(8'h81, 3'd7, 1'b1);
    rk(8'h06, 3'd1, 1'b0);
    rd_chk(`SAP_OFS_STATUS, 1'b0, 32'h4, "status");
    wr_reg(`SAP_OFS_VEC_NS, VB_NS, 1'b1);
    wr_reg(`SAP_OFS_VEC_S, VB_S, 1'b0);
    wr_reg(`SAP_OFS_VEC_MON, VB_M, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    wchk(1'b0, VB_S);
    pulse(0, 2'b01);
    wchk(1'b0, VB_M);
    pulse(5, 2'b01);
    wchk(1'b1, VB_NS);
    chk("core1 vector", VB_S, vb[1]);
    chk("core1 ns", 32'h0, 32'(cns[1]));
    pulse(1, 2'b01);
    wchk(1'b1, VB_NS);
    wr_reg(`SAP_OFS_TRAPCFG, 32'hf, 1'b0);
    wr_reg(`SAP_OFS_TRAPCFG, 32'h0, 1'b1);
    for (int i = 1; i < 5; i++) begin
      pulse(i, 2'b01);
      wchk(1'b0, VB_M);
      pulse(6, 2'b01);
      wchk(1'b1, VB_NS);
    end
    rd_chk(`SAP_OFS_STATUS, 1'b0, 32'h6, "status");
    coh <= 1'b1;
    fw(32'h2000_0100, 1'b0, 3'b010);
    coh <= 1'b0;
    dbg(2'b00, 2'b00, 2'b11, 2'b01);
    lk(32'h1234_5660, 1'b0, 1'b0);
    lk(32'h1234_5660, 1'b0, 1'b1);
    lk(32'h1234_5660, 1'b1, 1'b0);
    lk(32'h1234_5660, 1'b1, 1'b1);
    lk(32'h1234_5660, 1'b0, 1'b1);
    lk(32'h5234_5660, 1'b0, 1'b0);
    report_and_stop();
  end
endmodule : sap_top_tb_top
`default_nettype wire
